/* pkg/phase_meas_pkg.sv */
// Constants for the clock phase measurement block: register map, fields, timing.
// Assumes a single 40 MHz system clock and an APB master with 32-bit data.
package phase_meas_pkg;
  // System clock rate in MHz.
  localparam int CLK_MHZ = 40;
  // Longest converter conversion time, and the derived cycle bound (rounded down).
  localparam int CONV_MAX_NS = 20000;
  localparam int CONV_MAX_CYC = CONV_MAX_NS * CLK_MHZ / 1000;
  // Selector test counter step time, and the derived cycle count.
  localparam int TEST_STEP_NS = 1000000;
  localparam int TEST_STEP_CYC = TEST_STEP_NS / 1000 * CLK_MHZ;
  // Serial clock half period in system cycles.
  localparam int SCLK_HALF_CYC = 2;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SELECT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0c;
  // Control register fields.
  localparam int TRIG_BIT = 0;
  // Select register fields.
  localparam int REF_IDX_LSB = 0;
  localparam int REF_SRC_LSB = 4;
  localparam int VAR_IDX_LSB = 8;
  localparam int VAR_SRC_LSB = 12;
  // Status register fields.
  localparam int READY_BIT = 0;
  localparam int BUSY_BIT = 1;
  // Reset values.
  localparam logic [13:0] SELECT_RST = 14'h0000;
  // Reference sources: module clock, local true, local inverted, local delayed.
  localparam logic [1:0] REF_MODULE = 2'h0;
  localparam logic [1:0] REF_LOCAL = 2'h1;
  localparam logic [1:0] REF_LOCAL_INV = 2'h2;
  localparam logic [1:0] REF_LOCAL_DLY = 2'h3;
  // Variable sources: module clock, or one of three fibre clocks (1..3).
  localparam logic [1:0] VAR_MODULE = 2'h0;
  // Selector test settings.
  localparam logic [1:0] SELTEST_NORMAL = 2'h0;
  localparam logic [1:0] SELTEST_COUNT = 2'h1;
  localparam logic [1:0] SELTEST_ZERO = 2'h2;
  localparam logic [1:0] SELTEST_ZERO_ONE = 2'h3;
  // Converter sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_CONVERT, ST_READ, ST_DONE} conv_state_t;
endpackage

/* design/clock_phase_measurement.sv */
// Clock selection, phase detector and serial converter sequencer with an APB slave.
// Assumes all pins synchronous to REF_CLK_I; clock inputs are sampled as data.
//
// What this block does
// RULE1 - Reference picks one of sixteen module clocks or local clock, true/inverted/delayed.
// RULE2 - Variable picks one of sixteen module clocks or one of three fibre clocks.
// RULE3 - Sixteen-way pick is four 4:1 selectors then a source selector.
// RULE4 - Phase detector divides clock by four before the exclusive-or compare.
// RULE5 - The other clock path is resampled by the opposite clock, not divided.
// RULE6 - Resampling uses the opposite edge to the divider's edge.
// RULE7 - In-phase clocks give quadrature exclusive-or inputs, so no dead zone. Here in-phase inputs sit an eighth of the divided period apart.
// RULE8 - Reading wraps where reference rise meets variable fall.
// RULE9 - Conversion result carries at least ten bits.
// RULE10 - Converter is serial; controller allows up to 20 us conversion time.
// RULE11 - Bus logic sequences converter and assembles serial bits into a word.
// RULE12 - Software starts a conversion by writing one to the trigger bit.
// RULE13 - After the conversion the ready flag rises and the result is readable.
// RULE14 - Trigger bit clears itself during conversion so another command is accepted.
// RULE15 - Ready flag stays low while a conversion runs.
// RULE16 - Continuous converter test mode repeats conversions without software triggers.
// RULE17 - Selector test mode drives both selections from a six-bit millisecond counter.
// RULE18 - A trigger written during a running conversion is ignored.
// RULE19 - Result is right-aligned with zeros above.
//
// Design decisions made here: the APB slave port and the register offsets.
module clock_phase_measurement #(
  parameter int RES_BITS = 10,
  parameter int TEST_STEP = phase_meas_pkg::TEST_STEP_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Clock inputs to compare.
  input wire logic [15:0] MOD_CLK_I,
  input wire logic LOCAL_CLK_I,
  input wire logic LOCAL_DLY_CLK_I,
  input wire logic [2:0] FIBRE_CLK_I,
  // Test settings from jumpers.
  input wire logic [1:0] SEL_TEST_I,
  input wire logic CONV_TEST_I,
  // Phase detector and selected clocks.
  output logic PD_PULSE_O,
  output logic REF_SEL_O,
  output logic VAR_SEL_O,
  output logic FIBRE_TX_EN_O,
  // Serial converter.
  output logic ADC_CONV_O,
  output logic ADC_CS_N_O,
  output logic ADC_SCLK_O,
  input wire logic ADC_BUSY_I,
  input wire logic ADC_SDO_I
);
  import phase_meas_pkg::*;

  // Four-to-one selector, used by every first-level bank and the source stage.
  function automatic logic pick4(input logic [3:0] d, input logic [1:0] s);
    pick4 = d[s];
  endfunction

  logic [13:0] select_r;
  logic trig_r;
  logic ready_r;
  logic [RES_BITS-1:0] result_r;
  logic [RES_BITS-1:0] shift_r;
  conv_state_t state_r;
  logic [5:0] test_cnt_r;
  logic [$clog2(TEST_STEP+1)-1:0] step_r;
  logic [$clog2(CONV_MAX_CYC+1)-1:0] wait_r;
  logic [$clog2(RES_BITS+1)-1:0] bit_r;
  logic [$clog2(SCLK_HALF_CYC+1)-1:0] sdiv_r;
  logic wr_go;
  logic rd_go;
  logic [3:0] ref_idx;
  logic [1:0] ref_src;
  logic [3:0] var_idx;
  logic [1:0] var_src;
  logic [3:0] ref_bank;
  logic [3:0] var_bank;
  logic ref_mux;
  logic var_mux;
  logic ref_prev_r;
  logic var_prev_r;
  logic [1:0] div_r;
  logic resamp_r;
  logic sclk_en;

  // A write takes effect at the edge where the master sees pready; a read takes effect one edge earlier, as pready rises.
  assign wr_go = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign rd_go = PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I;

  // Registered pready gives exactly one wait state and a clean registered answer.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O &&
                   !(PADDR_I inside {CTRL_OFS, SELECT_OFS, STATUS_OFS, RESULT_OFS});
    end
  end

  // Read data is latched while pready rises; unmapped addresses read zero.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (PADDR_I)
        CTRL_OFS: PRDATA_O <= {31'h0000_0000, trig_r};
        SELECT_OFS: PRDATA_O <= {18'h0_0000, select_r};
        STATUS_OFS: PRDATA_O <= {30'h0000_0000, state_r != ST_IDLE, ready_r};
        RESULT_OFS: PRDATA_O <= 32'(result_r); // RULE19
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Clock selection settings written by software.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      select_r <= SELECT_RST;
    end else if (wr_go && PADDR_I == SELECT_OFS) begin
      select_r <= PWDATA_I[13:0];
    end
  end

  // Selector test counter; one step per millisecond when counting is selected.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I || SEL_TEST_I != SELTEST_COUNT) begin
      step_r <= '0;
      test_cnt_r <= 6'h00;
    end else if (step_r == $bits(step_r)'(TEST_STEP - 1)) begin
      step_r <= '0;
      test_cnt_r <= test_cnt_r + 6'h01; // RULE17
    end else begin
      step_r <= step_r + 1'b1;
    end
  end

  // Selection addresses: software, counter or fixed test settings.
  always_comb begin
    ref_idx = select_r[REF_IDX_LSB +: 4];
    ref_src = select_r[REF_SRC_LSB +: 2];
    var_idx = select_r[VAR_IDX_LSB +: 4];
    var_src = select_r[VAR_SRC_LSB +: 2];
    unique case (SEL_TEST_I)
      SELTEST_COUNT: begin
        ref_idx = test_cnt_r[3:0]; // RULE17
        ref_src = test_cnt_r[5:4];
        var_idx = test_cnt_r[3:0];
        var_src = test_cnt_r[5:4];
      end
      SELTEST_ZERO: begin
        ref_idx = 4'h0;
        ref_src = REF_MODULE;
        var_idx = 4'h0;
        var_src = VAR_MODULE;
      end
      SELTEST_ZERO_ONE: begin
        ref_idx = 4'h0;
        ref_src = REF_MODULE;
        var_idx = 4'h1;
        var_src = VAR_MODULE;
      end
      default: begin
      end
    endcase
  end

  // First level: four banks of 4:1 selectors on each path.
  for (genvar b = 0; b < 4; b++) begin : g_bank
    assign ref_bank[b] = pick4(MOD_CLK_I[4*b +: 4], ref_idx[1:0]); // RULE3
    assign var_bank[b] = pick4(MOD_CLK_I[4*b +: 4], var_idx[1:0]); // RULE3
  end

  // Second level picks a bank, then the source stage picks module or other clocks.
  always_comb begin
    ref_mux = pick4(ref_bank, ref_idx[3:2]);
    var_mux = pick4(var_bank, var_idx[3:2]);
    if (ref_src != REF_MODULE) begin
      ref_mux = pick4({LOCAL_DLY_CLK_I, !LOCAL_CLK_I, LOCAL_CLK_I, 1'b0}, ref_src); // RULE1
    end
    if (var_src != VAR_MODULE) begin
      var_mux = pick4({FIBRE_CLK_I, 1'b0}, var_src); // RULE2
    end
  end

  // Selected clocks are registered before use so the detector sees clean samples.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      REF_SEL_O <= 1'b0;
      VAR_SEL_O <= 1'b0;
      ref_prev_r <= 1'b0;
      var_prev_r <= 1'b0;
      FIBRE_TX_EN_O <= 1'b0;
    end else begin
      REF_SEL_O <= ref_mux;
      VAR_SEL_O <= var_mux;
      ref_prev_r <= REF_SEL_O;
      var_prev_r <= VAR_SEL_O;
      FIBRE_TX_EN_O <= SEL_TEST_I == SELTEST_COUNT;
    end
  end

  // Divider counts reference rising edges; resampler catches it on variable falls.
  // The opposite edge keeps the resampler away from the divider's own transition.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      div_r <= 2'h0;
      resamp_r <= 1'b0;
      PD_PULSE_O <= 1'b0;
    end else begin
      if (REF_SEL_O && !ref_prev_r) begin
        div_r <= div_r + 2'h1; // RULE4
      end
      if (!VAR_SEL_O && var_prev_r) begin
        resamp_r <= div_r[1]; // RULE5 RULE6
      end
      // Inputs sit an eighth of the divided period apart when in phase; wrap is where a reference rise
      // meets a variable fall, as the resampler then flips its captured value.
      PD_PULSE_O <= div_r[1] ^ resamp_r; // RULE7 RULE8
    end
  end

  // Serial clock enable, running only during readout.
  assign sclk_en = sdiv_r == $bits(sdiv_r)'(SCLK_HALF_CYC - 1);

  // Trigger bit: accepted only while idle, cleared by the sequencer once started.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      trig_r <= 1'b0;
    end else if (wr_go && PADDR_I == CTRL_OFS && PWDATA_I[TRIG_BIT] && state_r == ST_IDLE) begin
      trig_r <= 1'b1; // RULE12 RULE18
    end else if (state_r == ST_START) begin
      trig_r <= 1'b0; // RULE14
    end
  end

  // Converter sequencer: start pulse, wait for conversion, shift bits, publish.
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b0;
      result_r <= '0;
      shift_r <= '0;
      wait_r <= '0;
      bit_r <= '0;
      sdiv_r <= '0;
      ADC_CONV_O <= 1'b0;
      ADC_CS_N_O <= 1'b1;
      ADC_SCLK_O <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (trig_r || CONV_TEST_I) begin
            state_r <= ST_START; // RULE16
            ready_r <= 1'b0; // RULE15
            ADC_CONV_O <= 1'b1;
          end
        end
        ST_START: begin
          ADC_CONV_O <= 1'b0;
          wait_r <= '0;
          state_r <= ST_CONVERT;
        end
        ST_CONVERT: begin
          // Leave on the converter's done indication, or at the longest time.
          wait_r <= wait_r + 1'b1;
          if (!ADC_BUSY_I || wait_r == $bits(wait_r)'(CONV_MAX_CYC - 1)) begin
            state_r <= ST_READ; // RULE10
            ADC_CS_N_O <= 1'b0;
            bit_r <= '0;
            sdiv_r <= '0;
          end
        end
        ST_READ: begin
          sdiv_r <= sclk_en ? '0 : sdiv_r + 1'b1;
          if (sclk_en) begin
            ADC_SCLK_O <= !ADC_SCLK_O;
            // Data is taken on the rising serial edge, most significant bit first.
            if (!ADC_SCLK_O) begin
              shift_r <= {shift_r[RES_BITS-2:0], ADC_SDO_I}; // RULE11 RULE9
              bit_r <= bit_r + 1'b1;
            end else if (bit_r == $bits(bit_r)'(RES_BITS)) begin
              state_r <= ST_DONE;
              ADC_CS_N_O <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          result_r <= shift_r; // RULE11
          ready_r <= 1'b1; // RULE13
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* sim/clock_phase_measurement_monitor.sv */
// Concurrent checks on the bus handshake, test outputs and converter pins.
// Assumes one clock domain with a synchronous active-high reset.
module clock_phase_measurement_monitor #(
  parameter int RES_BITS = 10,
  parameter int TEST_STEP = 8
) (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Bus handshake.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Test setting and converter pins.
  input wire logic [1:0] SEL_TEST_I,
  input wire logic FIBRE_TX_EN_O,
  input wire logic ADC_CONV_O,
  input wire logic ADC_CS_N_O,
  input wire logic ADC_SCLK_O,
  input wire logic ADC_BUSY_I
);
  logic sclk_q;
  int rises;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Serial clock rises in one frame; the count clears while deselected.
  always_ff @(posedge REF_CLK_I) begin
    sclk_q <= ADC_SCLK_O;
    if (SYS_RST_I || ADC_CS_N_O) rises <= 0;
    else if (ADC_SCLK_O && !sclk_q) rises <= rises + 1;
  end
  a_ready_wait: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
    else $error("bus answer not after one wait state");
  a_ready_req: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I))
    else $error("bus answer outside an access");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without answer");
  a_start_gap: assert property (ADC_CONV_O |-> ADC_CS_N_O ##1 !ADC_CONV_O [*8])
    else $error("start pulse too long or repeated");
  a_sclk_frame: assert property (ADC_SCLK_O |-> !ADC_CS_N_O)
    else $error("serial clock outside a frame");
  a_sclk_half: assert property ($rose(ADC_SCLK_O) |=> ADC_SCLK_O ##1 !ADC_SCLK_O)
    else $error("serial clock high time wrong");
  a_read_idle: assert property ($fell(ADC_CS_N_O) |-> !ADC_BUSY_I)
    else $error("readout while converting");
  a_bit_count: assert property ($rose(ADC_CS_N_O) |-> rises == RES_BITS)
    else $error("wrong bit count in frame");
  a_fibre_tx: assert property (FIBRE_TX_EN_O == ($past(SEL_TEST_I) == 2'h1))
    else $error("fibre transmit enable wrong");
  c_start: cover property (ADC_CONV_O);
  c_slverr: cover property (PSLVERR_O);
  c_fibre: cover property (FIBRE_TX_EN_O);
endmodule

bind clock_phase_measurement clock_phase_measurement_monitor #(.RES_BITS(RES_BITS),
  .TEST_STEP(TEST_STEP)) mon (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SEL_TEST_I(SEL_TEST_I),
  .FIBRE_TX_EN_O(FIBRE_TX_EN_O), .ADC_CONV_O(ADC_CONV_O), .ADC_CS_N_O(ADC_CS_N_O),
  .ADC_SCLK_O(ADC_SCLK_O), .ADC_BUSY_I(ADC_BUSY_I));

/* sim/adc_model.sv */
// Serial converter model: busy for a set time after a start, then shifts out MSB first.
// Assumes start, select and serial clock all change on the system clock.
module adc_model (
  // Controller side.
  input wire logic clk_i,
  input wire logic conv_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  // Bench settings.
  input wire logic [9:0] val_i,
  input wire logic [9:0] dly_i,
  // Converter outputs.
  output logic busy_o,
  output logic sdo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic sclk_q = 1'b0;
  logic tog = 1'b0;
  logic [9:0] sh = 10'h000;
  // Busy time is set by the bench and stays under the 20 us ceiling.
  always @(posedge clk_i) begin
    if (conv_i) cnt <= int'(dly_i);
    else if (cnt > 0) cnt <= cnt - 1;
    sclk_q <= sclk_i;
    tog <= ~tog;
    if (cs_n_i) sh <= val_i;
    else if (sclk_q && !sclk_i) sh <= {sh[8:0], 1'b0};
  end
  assign busy_o = (cnt > 0);
  // A deselected output toggles so a stale bit never passes for data.
  assign sdo_o = cs_n_i ? tog : sh[9];
endmodule

/* sim/clock_phase_measurement_test.sv */
// Self-checking bench: APB master, random clock inputs and a serial converter model.
// Assumes a 40 MHz clock and one-word APB transfers with one idle cycle between.
module clock_phase_measurement_test import phase_meas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ltc = 1'b0, ldc = 1'b0;
  logic ctest = 1'b0, rdy, err, pd, rsel, vsel, ftx, conv, csn, sclk, busy, sdo;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] mclk = 16'h0;
  logic [2:0] fclk = 3'h0;
  logic [1:0] stest = 2'h0;
  logic [9:0] val = 10'h0, dly = 10'h0;
  int n_fail = 0, n_checks = 0, n_conv = 0, cyc = 0, rs = 0, ri = 0, vs = 0, vi = 0;
  int ph = -1, ns = 0, hi[6];
  int exq[$];
  int dl[3] = '{3, 40, 700};
  clock_phase_measurement #(.TEST_STEP(8)) uut (.REF_CLK_I(clk), .SYS_RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err), .MOD_CLK_I(mclk), .LOCAL_CLK_I(ltc),
    .LOCAL_DLY_CLK_I(ldc), .FIBRE_CLK_I(fclk), .SEL_TEST_I(stest), .CONV_TEST_I(ctest),
    .PD_PULSE_O(pd), .REF_SEL_O(rsel), .VAR_SEL_O(vsel), .FIBRE_TX_EN_O(ftx),
    .ADC_CONV_O(conv), .ADC_CS_N_O(csn), .ADC_SCLK_O(sclk), .ADC_BUSY_I(busy), .ADC_SDO_I(sdo));
  adc_model adc (.clk_i(clk), .conv_i(conv), .cs_n_i(csn), .sclk_i(sclk), .val_i(val),
    .dly_i(dly), .busy_o(busy), .sdo_o(sdo));
  // Free-running 25 ns clock.
  initial forever #12.5 clk = ~clk;
  // Clock inputs are random data, or a square wave and a copy delayed by ph cycles.
  // Starts and edges spent in counter test mode are tallied; a hang is cut short.
  always @(posedge clk) begin
    mclk <= (ph < 0) ? 16'($urandom) : {14'h0000, ((cyc + 8 - ph) % 8) < 4, (cyc % 8) < 4};
    ns <= (stest == SELTEST_COUNT) ? ns + 1 : 0;
    fclk <= 3'($urandom);
    ltc <= 1'($urandom);
    ldc <= 1'($urandom);
    if (conv === 1'b1) n_conv++;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // One transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // The wait has no limit of its own; the slave decides how long it takes, and only the bench timeout cuts a hang short.
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Expected selected clocks from the inputs the design sampled at this edge.
  // In counter mode the six-bit count advances once every 8 edges (TEST_STEP of the uut).
  function automatic logic [1:0] esel();
    int a, b, c, d, t;
    t = (ns / 8) % 64;
    a = stest[1] ? 0 : (stest[0] ? t / 16 : rs);
    b = stest[1] ? 0 : (stest[0] ? t % 16 : ri);
    c = stest[1] ? 0 : (stest[0] ? t / 16 : vs);
    d = stest[1] ? int'(stest[0]) : (stest[0] ? t % 16 : vi);
    esel[1] = (a == 0) ? mclk[b] : (a == 1) ? ltc : (a == 2) ? ~ltc : ldc;
    esel[0] = (c == 0) ? mclk[d] : fclk[c-1];
  endfunction
  task automatic sel_chk();
    logic [1:0] x;
    repeat (2) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      x = esel();
      #1 chk(32'({rsel, vsel}), 32'(x));
    end
    @(posedge clk);
  endtask
  task automatic wait_ready();
    logic [31:0] q;
    logic e;
    int t;
    t = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0, q, e);
      t++;
    end while (q[READY_BIT] !== 1'b1 && t < 400);
  endtask
  task stop_test();
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] q, x;
    logic e;
    void'($urandom(2593));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset value, then an unmapped write and read.
    apb(1'b0, SELECT_OFS, 32'h0, q, e);
    chk(q, 32'(SELECT_RST));
    apb(1'b1, 8'h40, 32'hffff_ffff, q, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    // Every reference and variable source with random indices.
    for (int i = 0; i < 4; i++) begin
      rs = i;
      vs = i;
      ri = $urandom_range(15);
      vi = $urandom_range(15);
      x = 32'({vs[1:0], vi[3:0], 2'b00, rs[1:0], ri[3:0]});
      apb(1'b1, SELECT_OFS, x, q, e);
      apb(1'b0, SELECT_OFS, 32'h0, q, e);
      chk(q, x);
      sel_chk();
    end
    // Fixed selector test settings, then the counter setting with fibre transmit.
    stest <= SELTEST_ZERO_ONE;
    sel_chk();
    stest <= SELTEST_ZERO;
    sel_chk();
    stest <= SELTEST_COUNT;
    repeat (3) @(posedge clk);
    chk(32'(ftx), 32'h1);
    repeat (50) sel_chk();
    stest <= SELTEST_NORMAL;
    // Triggered conversions, short to long, with a repeated trigger mid-run.
    foreach (dl[k]) begin
      dly <= 10'(dl[k]);
      val <= 10'($urandom_range(1023));
      @(posedge clk);
      exq.push_back(int'(val));
      apb(1'b1, CTRL_OFS, 32'h1, q, e);
      apb(1'b0, STATUS_OFS, 32'h0, q, e);
      chk(32'(q[READY_BIT]), 32'h0);
      apb(1'b1, CTRL_OFS, 32'h1, q, e);
      apb(1'b0, CTRL_OFS, 32'h0, q, e);
      chk(32'(q[TRIG_BIT]), 32'h0);
      wait_ready();
      apb(1'b0, RESULT_OFS, 32'h0, q, e);
      chk(q, 32'(exq.pop_front()));
      chk(32'(n_conv), 32'(k + 1));
    end
    // Continuous mode restarts the converter with no trigger.
    dly <= 10'd20;
    val <= 10'h2a5;
    x = 32'(n_conv);
    ctest <= 1'b1;
    repeat (400) @(posedge clk);
    ctest <= 1'b0;
    chk(32'(n_conv >= int'(x) + 3), 32'h1);
    repeat (100) @(posedge clk);
    wait_ready();
    apb(1'b0, RESULT_OFS, 32'h0, q, e);
    chk(q, 32'h2a5);
    // Module clock 0 against module clock 1, the same wave delayed by s cycles.
    // The pulse duty must grow with the delay and drop once the variable fall
    // has passed the reference rise, which is where the reading wraps.
    apb(1'b1, SELECT_OFS, 32'h0000_0100, q, e);
    for (int s = 0; s < 6; s++) begin
      ph = s;
      repeat (40) @(posedge clk);
      hi[s] = 0;
      repeat (64) begin
        @(posedge clk);
        hi[s] += int'(pd);
      end
    end
    for (int s = 1; s < 4; s++) begin
      chk(32'(hi[s] > hi[s-1]), 32'h1);
    end
    chk(32'(hi[5] < hi[3]), 32'h1);
    stop_test();
  end
endmodule
